// ==== common/clkmon_pkg.sv ====
package clkmon_pkg;

   typedef logic [3:0] rate_code_t;
   typedef logic [3:0] ratio_code_t;
   typedef logic [2:0] mclk_sel_t;

   localparam int NUM_RATES  = 9;
   localparam int NUM_RATIOS = 13;

   // frame rates of the 48 kHz and 44.1 kHz families, in hertz
   localparam int unsigned RATE_48_HZ [NUM_RATES] = '{
      8000, 16000, 24000, 32000, 48000, 96000, 192000, 384000, 768000};
   localparam int unsigned RATE_44_HZ [NUM_RATES] = '{
      7350, 14700, 22050, 29400, 44100, 88200, 176400, 352800, 705600};

   // bit clocks per frame for codes 0 to 12
   localparam int unsigned BIT_RATIO [NUM_RATIOS] = '{
      16, 24, 32, 48, 64, 96, 128, 192, 256, 384, 512, 1024, 2048};

   // master clock per frame for ratio codes 0 to 7
   localparam int unsigned MCLK_RATIO [8] = '{
      64, 256, 384, 512, 768, 1024, 1536, 2304};

   // master clock frequency in kHz for select codes 0 to 7
   localparam int unsigned MCLK_KHZ [8] = '{
      12000, 12288, 13000, 16000, 19200, 19680, 24000, 24576};

endpackage : clkmon_pkg

// ==== common/clkmon_regs.svh ====
`ifndef CLKMON_REGS_SVH
`define CLKMON_REGS_SVH

// register offsets on the control port
`define STS_ADDR          8'h15
`define SRC_ADDR          8'h16

// reset values
`define STS_RESET         8'hFF
`define SRC_RESET         8'h10

// status fields
`define STS_RATE_MSB      7
`define STS_RATE_LSB      4
`define STS_RATIO_MSB     3
`define STS_RATIO_LSB     0
`define CODE_INVALID      4'hF

// clock source fields
`define SRC_ROOT_BIT      7
`define SRC_MODE_BIT      6
`define SRC_RATIO_MSB     5
`define SRC_RATIO_LSB     3
`define SRC_RSVD_MSB      2
`define SRC_RSVD_LSB      0

// system clock and frame period tolerance
`define CLK_HZ            32'h05F5_E100
`define TOL_PCT           32'h0000_0002
`define PCT_FULL          32'h0000_0064

// frame timeout in clock cycles, longer than the slowest frame
`define FRAME_TIMEOUT     16384

`endif

// ==== design/audio_serial_clock_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "clkmon_regs.svh"

//
// Summary of operation
// - status bits 7-4 report detected frame rate, codes 0-8 for rate pairs.
// - unmatched frame rate reports code 15; codes 9-14 never reported.
// - status bits 3-0 report bit-to-frame clock ratio, 16 to 2048, else 15.
// - status register resets to all ones, both fields invalid.
// - slave auto mode, PLL off: bit 7 picks bit clock or master clock root.
// - master auto mode: bit 6 picks absolute frequency or frame multiple.
// - bits 5-3 give master clock to frame ratio, 64 up to 2304.
// - clock source bits 2-0 read zero; software writes only zero there.
// - clock source resets to ratio code 2, bits 7 and 6 clear.
// - slave mode takes bit and frame clocks in; master mode drives them.
// - auto PLL disable set makes root-source selection apply in slave mode.
// - frequency select field gives master clock, 12 to 24.576 MHz.
//
module audio_serial_clock_monitor
   import clkmon_pkg::*;
#(
   parameter int FRAME_TIMEOUT = `FRAME_TIMEOUT,
   parameter int BCLK_HALF     = 4,
   parameter int FRAME_BITS    = 64
) (
   input  wire logic       clock_i,              // system clock, 100 MHz
   input  wire logic       rstn_i,               // async reset, active low
   input  wire logic [7:0] reg_addr_i,           // register offset
   input  wire logic [7:0] reg_wdata_i,          // write data
   input  wire logic       reg_wr_i,             // write strobe
   input  wire logic       reg_rd_i,             // read strobe
   output logic      [7:0] reg_rdata_o,          // read data, next cycle
   input  wire logic       port_role_select_i,   // 1 master, 0 slave
   input  wire logic       auto_clk_enable_i,    // auto clock config on
   input  wire logic       auto_pll_disable_i,   // PLL off in auto mode
   input  wire mclk_sel_t  master_freq_select_i, // master clock freq code
   input  wire logic       bclk_i,               // bit clock pin level
   input  wire logic       fsync_i,              // frame clock pin level
   output logic            bclk_o,               // bit clock drive
   output logic            bclk_oe_o,            // bit clock drive enable
   output logic            fsync_o,              // frame clock drive
   output logic            fsync_oe_o,           // frame clock drive enable
   output logic            root_from_mclk_o,     // root clock is master clk
   output logic            mclk_from_ratio_o,    // mclk given as fs multiple
   output logic     [11:0] mclk_fs_ratio_o,      // master clock per frame
   output logic     [14:0] mclk_freq_khz_o,      // master clock in kHz
   output rate_code_t      detected_frame_rate_o,    // status bits 7-4
   output ratio_code_t     detected_bit_frame_ratio_o // status bits 3-0
);

   localparam int TMO_W = $clog2(FRAME_TIMEOUT + 1);
   localparam int DIV_W = $clog2(BCLK_HALF + 1);
   localparam int BIT_W = $clog2(FRAME_BITS + 1);

   // ---------------- register access ----------------
   logic [7:0]  clock_source_config;
   logic [7:0]  serial_clock_monitor_status;
   logic [7:0]  next_rdata;
   logic [7:0]  next_src;

   wire sel_sts = (reg_addr_i == `STS_ADDR);
   wire sel_src = (reg_addr_i == `SRC_ADDR);

   // reserved bits stored and read as zero
   assign next_src = {reg_wdata_i[`SRC_ROOT_BIT:`SRC_RATIO_LSB],
                      3'h0};

   // unmapped offsets read as zero
   assign next_rdata = sel_sts ? serial_clock_monitor_status :
                       sel_src ? clock_source_config : 8'h00;

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         clock_source_config <= `SRC_RESET;
      end else if (reg_wr_i && sel_src) begin
         clock_source_config <= next_src;
      end
   end
   // no write path exists for the status register

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         reg_rdata_o <= next_rdata;
      end
   end

   // ---------------- clock source decode ----------------
   wire       role_master = port_role_select_i;
   wire       cfg_root    = clock_source_config[`SRC_ROOT_BIT];
   wire       cfg_mode    = clock_source_config[`SRC_MODE_BIT];
   mclk_sel_t cfg_ratio;
   assign cfg_ratio = clock_source_config[`SRC_RATIO_MSB:`SRC_RATIO_LSB];

   wire next_root_mclk = ~role_master & auto_clk_enable_i &
                         auto_pll_disable_i & cfg_root;
   wire next_from_ratio = role_master & auto_clk_enable_i & cfg_mode;

   wire [11:0] next_mclk_ratio = 12'(MCLK_RATIO[cfg_ratio]);
   wire [14:0] next_mclk_khz   = 15'(MCLK_KHZ[master_freq_select_i]);

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         root_from_mclk_o  <= 1'b0;
         mclk_from_ratio_o <= 1'b0;
         mclk_fs_ratio_o   <= 12'h000;
         mclk_freq_khz_o   <= 15'h0000;
      end else begin
         root_from_mclk_o  <= next_root_mclk;
         mclk_from_ratio_o <= next_from_ratio;
         mclk_fs_ratio_o   <= next_mclk_ratio;
         mclk_freq_khz_o   <= next_mclk_khz;
      end
   end

   // ---------------- master mode clock generation ----------------
   logic [DIV_W-1:0] div_cnt;
   logic [BIT_W-1:0] bit_cnt;
   wire  div_wrap  = (div_cnt == DIV_W'(BCLK_HALF - 1));
   wire  fall_now  = div_wrap & bclk_o;
   wire  bit_last  = (bit_cnt == BIT_W'(FRAME_BITS - 1));
   wire  [BIT_W-1:0] next_bit = bit_last ? '0 : bit_cnt + BIT_W'(1);

   // drive both clocks only in master mode
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         bclk_oe_o  <= 1'b0;
         fsync_oe_o <= 1'b0;
      end else begin
         bclk_oe_o  <= role_master;
         fsync_oe_o <= role_master;
      end
   end

   // frame pulse is one bit wide, changed on the falling bit clock
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         div_cnt <= '0;
         bit_cnt <= '0;
         bclk_o  <= 1'b0;
         fsync_o <= 1'b0;
      end else if (!role_master) begin
         div_cnt <= '0;
         bit_cnt <= '0;
         bclk_o  <= 1'b0;
         fsync_o <= 1'b0;
      end else begin
         div_cnt <= div_wrap ? '0 : div_cnt + DIV_W'(1);
         if (div_wrap) begin
            bclk_o <= ~bclk_o;
         end
         if (fall_now) begin
            bit_cnt <= next_bit;
            fsync_o <= (next_bit == '0);
         end
      end
   end

   // ---------------- frame rate measurement ----------------
   logic             fs_sync;
   logic             fs_del;
   logic             fs_seen;
   logic [TMO_W-1:0] period;
   rate_code_t       next_rate;
   rate_code_t       rate_code;
   wire              fs_rise  = fs_sync & ~fs_del;
   wire              timed_out = (period == TMO_W'(FRAME_TIMEOUT));

   level_sync #(.WIDTH(1)) u_fs_sync (
      .clock_i (clock_i),
      .rstn_i  (rstn_i),
      .async_i (fsync_i),
      .sync_o  (fs_sync)
   );

   always_comb begin
      int unsigned lo;
      int unsigned hi;
      lo        = 0;
      hi        = 0;
      next_rate = `CODE_INVALID;
      for (int k = 0; k < NUM_RATES; k++) begin
         lo = `CLK_HZ / RATE_48_HZ[k] * (`PCT_FULL - `TOL_PCT) / `PCT_FULL;
         hi = `CLK_HZ / RATE_44_HZ[k] * (`PCT_FULL + `TOL_PCT) / `PCT_FULL;
         if (32'(period) >= lo && 32'(period) <= hi) begin
            next_rate = rate_code_t'(k);
         end
      end
   end

   // a stalled frame clock falls back to invalid after the timeout
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         fs_del    <= 1'b0;
         fs_seen   <= 1'b0;
         period    <= '0;
         rate_code <= `CODE_INVALID;
      end else begin
         fs_del <= fs_sync;
         if (fs_rise) begin
            fs_seen <= 1'b1;
            period  <= TMO_W'(1);
            if (fs_seen) begin
               rate_code <= next_rate;
            end
         end else if (timed_out) begin
            fs_seen   <= 1'b0;
            rate_code <= `CODE_INVALID;
         end else begin
            period <= period + TMO_W'(1);
         end
      end
   end

   // ---------------- bit ratio from the link domain ----------------
   ratio_code_t link_code;
   logic        link_tgl;
   logic        tgl_sync;
   logic        tgl_del;
   ratio_code_t ratio_code;

   frame_ratio_meter #(.CNT_W(12)) u_meter (
      .bclk_i       (bclk_i),
      .rstn_i       (rstn_i),
      .fsync_i      (fsync_i),
      .ratio_code_o (link_code),
      .done_tgl_o   (link_tgl)
   );

   level_sync #(.WIDTH(1)) u_tgl_sync (
      .clock_i (clock_i),
      .rstn_i  (rstn_i),
      .async_i (link_tgl),
      .sync_o  (tgl_sync)
   );

   // code is held a full frame after its toggle, so it is stable here
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tgl_del    <= 1'b0;
         ratio_code <= `CODE_INVALID;
      end else begin
         tgl_del <= tgl_sync;
         if (timed_out && !fs_rise) begin
            ratio_code <= `CODE_INVALID;
         end else if (tgl_sync ^ tgl_del) begin
            ratio_code <= link_code;
         end
      end
   end

   // ---------------- status register ----------------
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         serial_clock_monitor_status <= `STS_RESET;
         detected_frame_rate_o       <= `CODE_INVALID;
         detected_bit_frame_ratio_o  <= `CODE_INVALID;
      end else begin
         serial_clock_monitor_status <= {rate_code, ratio_code};
         detected_frame_rate_o       <= rate_code;
         detected_bit_frame_ratio_o  <= ratio_code;
      end
   end

endmodule : audio_serial_clock_monitor

`default_nettype wire

// ==== design/frame_ratio_meter.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "clkmon_regs.svh"

module frame_ratio_meter
   import clkmon_pkg::*;
#(
   parameter int CNT_W = 12
) (
   input  wire logic  bclk_i,        // link bit clock
   input  wire logic  rstn_i,        // async reset, active low
   input  wire logic  fsync_i,       // frame clock pin
   output ratio_code_t ratio_code_o, // last measured ratio code
   output logic       done_tgl_o     // toggles on each new code
);

   logic             fsync_s;
   logic             fsync_d;
   logic             seen;
   logic [CNT_W-1:0] cnt;
   ratio_code_t      next_code;
   wire              fs_rise = fsync_s & ~fsync_d;
   wire              cnt_max = &cnt;

   level_sync #(.WIDTH(1)) u_fs_sync (
      .clock_i (bclk_i),
      .rstn_i  (rstn_i),
      .async_i (fsync_i),
      .sync_o  (fsync_s)
   );

   always_comb begin
      next_code = `CODE_INVALID;
      for (int k = 0; k < NUM_RATIOS; k++) begin
         if (!cnt_max && cnt == CNT_W'(BIT_RATIO[k])) begin
            next_code = ratio_code_t'(k);
         end
      end
   end

   // bit clock may stop between frames; the code simply holds then
   always_ff @(posedge bclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         fsync_d      <= 1'b0;
         seen         <= 1'b0;
         cnt          <= '0;
         ratio_code_o <= `CODE_INVALID;
         done_tgl_o   <= 1'b0;
      end else begin
         fsync_d <= fsync_s;
         if (fs_rise) begin
            seen <= 1'b1;
            cnt  <= CNT_W'(1);
            if (seen) begin
               ratio_code_o <= next_code;
               done_tgl_o   <= ~done_tgl_o;
            end
         end else if (!cnt_max) begin
            cnt <= cnt + CNT_W'(1);
         end
      end
   end

endmodule : frame_ratio_meter

`default_nettype wire

// ==== design/level_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

module level_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clock_i,  // destination clock
   input  wire logic             rstn_i,   // async reset, active low
   input  wire logic [WIDTH-1:0] async_i,  // level from another domain
   output logic      [WIDTH-1:0] sync_o    // synchronised level
);

   logic [WIDTH-1:0] meta;

   // two flops per bit; the first is read only by the second
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clock_i or negedge rstn_i) begin
         if (!rstn_i) begin
            meta[i]   <= 1'b0;
            sync_o[i] <= 1'b0;
         end else begin
            meta[i]   <= async_i[i];
            sync_o[i] <= meta[i];
         end
      end
   end

endmodule : level_sync

`default_nettype wire

// ==== tb/audio_serial_clock_monitor_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module audio_serial_clock_monitor_tb;
   import clkmon_pkg::*;
   typedef struct packed {
      logic [11:0] bits;
      logic [15:0] period;
      logic [7:0]  sts;
   } row_t;
   row_t rows [7] = '{
      '{12'h040, 16'h5161, 8'h44}, '{12'h040, 16'h5894, 8'h44},
      '{12'h010, 16'h0516, 8'h80}, '{12'h018, 16'h0589, 8'h81},
      '{12'h800, 16'h5161, 8'h4C}, '{12'h064, 16'h5161, 8'h4F},
      '{12'h040, 16'h7530, 8'hF4}};
   logic clock_i = 1'b0;
   logic rstn_i, reg_wr_i, reg_rd_i, role, auto_en, pll_dis, run;
   logic [7:0] reg_addr_i, reg_wdata_i, rdata;
   logic [2:0] freq_sel;
   logic [11:0] bits;
   logic [15:0] period;
   wire logic bclk_o, bclk_oe_o, fsync_o, fsync_oe_o, p_bclk, p_fsync;
   wire logic root_o, ratio_mode_o;
   wire logic [7:0] rdata_o;
   wire logic [11:0] fs_ratio_o;
   wire logic [14:0] khz_o;
   wire rate_code_t rate_o;
   wire ratio_code_t bfr_o;
   wire logic bclk_w = bclk_oe_o ? bclk_o : p_bclk;
   wire logic fsync_w = fsync_oe_o ? fsync_o : p_fsync;
   int errors = 0;
   int total_checks = 0;
   int cycles = 0;
   audio_serial_clock_monitor #(.FRAME_TIMEOUT(4000)) dut (
      .clock_i(clock_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata_o),
      .port_role_select_i(role), .auto_clk_enable_i(auto_en),
      .auto_pll_disable_i(pll_dis), .master_freq_select_i(freq_sel),
      .bclk_i(bclk_w), .fsync_i(fsync_w), .bclk_o(bclk_o),
      .bclk_oe_o(bclk_oe_o), .fsync_o(fsync_o),
      .fsync_oe_o(fsync_oe_o), .root_from_mclk_o(root_o),
      .mclk_from_ratio_o(ratio_mode_o), .mclk_fs_ratio_o(fs_ratio_o),
      .mclk_freq_khz_o(khz_o), .detected_frame_rate_o(rate_o),
      .detected_bit_frame_ratio_o(bfr_o));
   host_audio_model host (.run_i(run), .bits_i(bits),
      .period_i(period), .bclk_o(p_bclk), .fsync_o(p_fsync));
   always #5 clock_i = ~clock_i;
   task automatic check(input logic [14:0] seen, input logic [14:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic acc(input logic w, input logic [7:0] a,
                      input logic [7:0] wd);
      @(posedge clock_i);
      reg_addr_i <= a;
      reg_wdata_i <= wd;
      reg_wr_i <= w;
      reg_rd_i <= !w;
      @(posedge clock_i);
      reg_wr_i <= 1'b0;
      reg_rd_i <= 1'b0;
      #1 rdata = rdata_o;
   endtask : acc
   task automatic give_verdict();
      if (errors == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : give_verdict
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 80000) begin
         errors++;
         give_verdict();
      end
   end
   initial begin
      {rstn_i, reg_wr_i, reg_rd_i, role, pll_dis, run} = 6'h00;
      {reg_addr_i, reg_wdata_i, freq_sel} = 19'h0_0000;
      {auto_en, bits, period} = 29'h0000_0000;
      repeat (8) @(posedge clock_i);
      rstn_i <= 1'b1;
      acc(1'b0, 8'h15, 8'h00);
      check(rdata, 8'hFF);
      acc(1'b0, 8'h16, 8'h00);
      check(rdata, 8'h10);
      acc(1'b0, 8'h17, 8'h00);
      check(rdata, 8'h00);
      acc(1'b1, 8'h15, 8'h00);
      acc(1'b0, 8'h15, 8'h00);
      check(rdata, 8'hFF);
      acc(1'b1, 8'h16, 8'hF8);
      acc(1'b0, 8'h16, 8'h00);
      check(rdata, 8'hF8);
      for (int c = 0; c < 8; c++) begin
         acc(1'b1, 8'h16, {2'b11, c[2:0], 3'b000});
         @(posedge clock_i);
         freq_sel <= c[2:0];
         @(posedge clock_i);
         #1;
         check(fs_ratio_o, 15'(MCLK_RATIO[c]));
         check(khz_o, 15'(MCLK_KHZ[c]));
      end
      for (int k = 0; k < 16; k++) begin
         // second pass runs with both source bits clear
         if (k == 8) begin
            acc(1'b1, 8'h16, 8'h10);
         end
         @(posedge clock_i);
         role <= k[1];
         pll_dis <= k[0];
         auto_en <= k[2];
         repeat (2) @(posedge clock_i);
         #1;
         check(root_o, !k[1] && k[0] && k[2] && !k[3]);
         check(ratio_mode_o, k[1] && k[2] && !k[3]);
         check(bclk_oe_o, k[1]);
      end
      @(posedge clock_i);
      role <= 1'b0;
      run <= 1'b1;
      foreach (rows[r]) begin
         bits <= rows[r].bits;
         period <= rows[r].period;
         repeat (2300 + 3 * rows[r].period / 10) @(posedge clock_i);
         acc(1'b0, 8'h15, 8'h00);
         check(rdata, rows[r].sts);
         check({rate_o, bfr_o}, rows[r].sts);
      end
      run <= 1'b0;
      repeat (6400) @(posedge clock_i);
      acc(1'b0, 8'h15, 8'h00);
      check(rdata, 8'hFF);
      @(posedge clock_i);
      role <= 1'b1;
      repeat (2000) @(posedge clock_i);
      acc(1'b0, 8'h15, 8'h00);
      // master defaults give 64 bits at about 195 kHz
      check(rdata, 8'h64);
      // reset in mid-run, master running, source register changed
      acc(1'b1, 8'h16, 8'hE8);
      @(posedge clock_i);
      rstn_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      #1;
      check(bclk_oe_o, 1'b0);
      check({rate_o, bfr_o}, 8'hFF);
      @(posedge clock_i);
      rstn_i <= 1'b1;
      acc(1'b0, 8'h15, 8'h00);
      check(rdata, 8'hFF);
      acc(1'b0, 8'h16, 8'h00);
      check(rdata, 8'h10);
      give_verdict();
   end
endmodule : audio_serial_clock_monitor_tb
bind audio_serial_clock_monitor clkmon_monitor mon (
   .clock_i(clock_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
   .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
   .port_role_select_i(port_role_select_i),
   .auto_clk_enable_i(auto_clk_enable_i),
   .auto_pll_disable_i(auto_pll_disable_i),
   .master_freq_select_i(master_freq_select_i),
   .bclk_o(bclk_o), .bclk_oe_o(bclk_oe_o), .fsync_oe_o(fsync_oe_o),
   .root_from_mclk_o(root_from_mclk_o),
   .mclk_from_ratio_o(mclk_from_ratio_o),
   .mclk_fs_ratio_o(mclk_fs_ratio_o),
   .mclk_freq_khz_o(mclk_freq_khz_o),
   .detected_frame_rate_o(detected_frame_rate_o),
   .detected_bit_frame_ratio_o(detected_bit_frame_ratio_o));
`default_nettype wire

// ==== tb/clkmon_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module clkmon_monitor
   import clkmon_pkg::*;
(
   input wire logic        clock_i,                   // system clock
   input wire logic        rstn_i,                    // reset, active low
   input wire logic [7:0]  reg_addr_i,                // register offset
   input wire logic        reg_rd_i,                  // read strobe
   input wire logic [7:0]  reg_rdata_o,               // read data
   input wire logic        port_role_select_i,        // 1 master
   input wire logic        auto_clk_enable_i,         // auto config on
   input wire logic        auto_pll_disable_i,        // pll off
   input wire mclk_sel_t   master_freq_select_i,      // freq code
   input wire logic        bclk_o,                    // bit clock drive
   input wire logic        bclk_oe_o,                 // bit clock enable
   input wire logic        fsync_oe_o,                // frame enable
   input wire logic        root_from_mclk_o,          // root choice
   input wire logic        mclk_from_ratio_o,         // spec mode
   input wire logic [11:0] mclk_fs_ratio_o,           // mclk per frame
   input wire logic [14:0] mclk_freq_khz_o,           // mclk in kHz
   input wire rate_code_t  detected_frame_rate_o,     // rate code
   input wire ratio_code_t detected_bit_frame_ratio_o // ratio code
);
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rstn_i);
   a_rate_not_reserved: assert property (
      !(detected_frame_rate_o inside {[4'h9:4'hE]}))
      else $error("rate code in reserved range");
   a_ratio_not_reserved: assert property (
      !(detected_bit_frame_ratio_o inside {4'hD, 4'hE}))
      else $error("ratio code in reserved range");
   a_oe_follows_role: assert property (
      rstn_i |=> bclk_oe_o == $past(port_role_select_i))
      else $error("drive enable does not follow role");
   a_oe_pair: assert property (
      fsync_oe_o == bclk_oe_o)
      else $error("frame and bit enables differ");
   a_slave_quiet: assert property (
      !bclk_oe_o && !$past(bclk_oe_o) |-> !bclk_o)
      else $error("bit clock driven in slave role");
   a_root_cause: assert property (
      root_from_mclk_o |-> $past(!port_role_select_i
         && auto_clk_enable_i && auto_pll_disable_i))
      else $error("master clock root without cause");
   a_ratio_mode_cause: assert property (
      mclk_from_ratio_o |->
         $past(port_role_select_i && auto_clk_enable_i))
      else $error("ratio mode outside master auto");
   a_sts_read: assert property (
      reg_rd_i && reg_addr_i == 8'h15 |=> reg_rdata_o
         == $past({detected_frame_rate_o, detected_bit_frame_ratio_o}))
      else $error("status read differs from fields");
   a_rsvd_read_zero: assert property (
      reg_rd_i && reg_addr_i == 8'h16 |=> reg_rdata_o[2:0] == 3'h0)
      else $error("reserved bits read nonzero");
   a_freq_lookup: assert property (
      rstn_i |=> mclk_freq_khz_o
         == 15'(MCLK_KHZ[$past(master_freq_select_i)]))
      else $error("wrong master clock frequency");
   a_ratio_table: assert property (
      rstn_i |=> mclk_fs_ratio_o inside {12'h040, 12'h100, 12'h180,
         12'h200, 12'h300, 12'h400, 12'h600, 12'h900})
      else $error("master ratio outside table");
endmodule : clkmon_monitor
`default_nettype wire

// ==== tb/host_audio_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module host_audio_model (
   input  wire logic        run_i,    // send frames
   input  wire logic [11:0] bits_i,   // bit clocks per frame
   input  wire logic [15:0] period_i, // frame period in ns
   output logic             bclk_o,   // bit clock, 6 ns
   output logic             fsync_o   // frame clock
);
   // clock stands still between frames so any rate fits a 6 ns bit clock
   initial begin
      bclk_o = 1'b0;
      fsync_o = 1'b0;
      forever begin
         wait (run_i);
         // host drives both clocks in slave role
         // frame clock high for half the bits; a one-bit pulse of 6 ns
         // could slip between two system clock edges
         fsync_o = 1'b1;
         for (int i = 0; i < bits_i; i++) begin
            #3 bclk_o = 1'b1;
            #3 bclk_o = 1'b0;
            fsync_o = (2 * (i + 1) < bits_i);
         end
         fsync_o = 1'b0;
         #(period_i - 6 * bits_i);
      end
   end
endmodule : host_audio_model
`default_nettype wire
